// ### rtl/rtc_match_counter.sv
// Real-time 40-bit match counter with an AHB-Lite register slave
//
// Function
// - Timekeeping is a 40-bit counter, loadable by software and advanced by clock.
// - Input clock divided by 128; counter advances only on divided clock.
// - Software writes a starting value through the counter load bytes.
// - Current count reads back at the same addresses used for loading.
// - Count bytes 1 to 4 read a snapshot taken when byte 0 is read, so multi-byte reads stay consistent.
// - match_out is 1 while counter equals match value, else 0.
// - power_sm_match_out mirrors match_out; it feeds the power state machine.
// - Match bits register reads all ones while counter equals match value.
// - With auto-clear set, the next tick after the counter equals match returns it to zero.
// - Auto-clear is suppressed while the match value is zero.
// - crystal_mode_out follows the crystal mode field of control.
// - crystal_select_out follows the crystal enable field of control.
// - Each register location carries exactly one byte of data.
//
// Design decisions made here: register access over AHB-Lite and the register offsets.
`timescale 1ns/100ps
module rtc_match_counter
    import rtc_match_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic rtc_clock_in,
    output logic [1:0] crystal_mode_out,
    output logic crystal_select_out,
    output logic match_out,
    output logic power_sm_match_out
);

    // Storage
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic [CNT_W-1:0] hold_q;
    logic [7:0] match_b_q [CNT_BYTES];
    logic [CNT_W-1:0] match_val;
    logic [CNT_W-1:0] match_d;
    ctrl_s ctrl_q;
    ctrl_s ctrl_d;
    logic match_flag_q;
    bus_req_s req_q;
    bus_req_s req_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    // Bus address phase decode
    logic [5:0] a_idx;
    logic addr_ok;
    logic size_ok;
    logic take;
    logic take_rd;
    logic hold_grab;

    // Word index and legality of the requested location
    assign a_idx = haddr[7:2];
    assign size_ok = (hsize == 3'h2);
    assign addr_ok = (haddr[31:8] == 24'h00_0000)
                     && (haddr[1:0] == 2'b00)
                     && (a_idx <= IDX_CTRL);

    // Transfer accepted on this edge
    assign take = hsel & htrans[1] & hready;
    assign take_rd = take & ~hwrite & addr_ok;

    // Reading the lowest count byte freezes the whole count
    assign hold_grab = take_rd && (a_idx == IDX_CNT);

    // Latched request for the data phase
    assign req_d.idx = a_idx;
    assign req_d.write = hwrite & size_ok;
    assign req_d.valid = take & addr_ok;

    // Data phase write strobes, one byte per location
    logic wr_en;
    logic [CNT_BYTES-1:0] wr_cnt;
    logic [CNT_BYTES-1:0] wr_match;
    logic wr_ctrl;
    logic [7:0] wbyte;

    // Only the low byte lane of a word carries data
    assign wr_en = req_q.valid & req_q.write;
    assign wbyte = hwdata[7:0];
    assign wr_ctrl = wr_en && (req_q.idx == IDX_CTRL);

    // Per-byte strobes and match storage
    genvar gi;
    generate
        for (gi = 0; gi < CNT_BYTES; gi++) begin : g_byte
            localparam logic [5:0] CNT_AT = 6'(IDX_CNT + gi);
            localparam logic [5:0] MATCH_AT = 6'(IDX_MATCH + gi);

            // Load strobe for one count byte
            assign wr_cnt[gi] = wr_en && (req_q.idx == CNT_AT);
            assign wr_match[gi] = wr_en && (req_q.idx == MATCH_AT);

            // Match value byte and its next value
            assign match_val[8*gi +: 8] = match_b_q[gi];
            assign match_d[8*gi +: 8] = wr_match[gi] ? wbyte
                                                     : match_b_q[gi];

            // Match byte register
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    match_b_q[gi] <= MATCH_RESET[8*gi +: 8];
                end else begin
                    match_b_q[gi] <= match_d[8*gi +: 8];
                end
            end
        end
    endgenerate

    // Control next value from the written byte
    assign ctrl_d.autoclr = wr_ctrl ? wbyte[CTRL_AUTOCLR_BIT]
                                    : ctrl_q.autoclr;
    assign ctrl_d.xen = wr_ctrl ? wbyte[CTRL_XEN_BIT] : ctrl_q.xen;
    assign ctrl_d.mode = wr_ctrl ? wbyte[CTRL_MODE_LSB +: 2]
                                 : ctrl_q.mode;

    // Prescaler and counter
    logic tick;
    logic equal_now;
    logic clear_ok;
    logic clear_now;
    logic [CNT_W-1:0] step_val;

    // Divide the crystal clock by 128; it must come from the oscillator
    rtc_prescaler u_prescaler (
        .hclk(hclk),
        .hresetn(hresetn),
        .clk_level(rtc_clock_in),
        .tick(tick)
    );

    // Compare and auto-clear qualification
    assign equal_now = (cnt_q == match_val);
    assign clear_ok = ctrl_q.autoclr && (match_val != MATCH_ZERO);
    assign clear_now = equal_now & clear_ok;

    // Step by one, wrapping naturally, or clear on match
    assign step_val = clear_now ? CNT_CLEAR
                                : CNT_W'(cnt_q + 1'b1);

    // Counter next value; a software byte load wins over the step
    always_comb begin
        cnt_d = cnt_q;
        if (tick) begin
            cnt_d = step_val;
        end
        for (int i = 0; i < CNT_BYTES; i++) begin
            if (wr_cnt[i]) begin
                cnt_d[8*i +: 8] = wbyte;
            end
        end
    end

    // Count, snapshot and match flag registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= CNT_RESET;
            hold_q <= CNT_RESET;
            match_flag_q <= 1'b1;
        end else begin
            cnt_q <= cnt_d;
            if (hold_grab) begin
                hold_q <= cnt_q;
            end
            match_flag_q <= (cnt_d == match_d);
        end
    end

    // Control register
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_q <= ctrl_s'(CTRL_RESET[3:0]);
        end else begin
            ctrl_q <= ctrl_d;
        end
    end

    // Read path, answered at the address phase edge
    logic [5:0] cnt_sel;
    logic [5:0] match_sel;
    logic [5:0] mbits_sel;
    logic in_cnt;
    logic in_match;
    logic in_mbits;
    logic [CNT_W-1:0] mbits_val;
    logic [CNT_W-1:0] cnt_view;
    logic [7:0] cnt_byte;
    logic [7:0] match_byte;
    logic [7:0] mbits_byte;
    logic [7:0] ctrl_byte;

    // Which region and which byte within it
    assign in_cnt = (a_idx < IDX_MATCH);
    assign in_match = (a_idx >= IDX_MATCH) && (a_idx < IDX_MBITS);
    assign in_mbits = (a_idx >= IDX_MBITS) && (a_idx < IDX_CTRL);
    assign cnt_sel = a_idx - IDX_CNT;
    assign match_sel = a_idx - IDX_MATCH;
    assign mbits_sel = a_idx - IDX_MBITS;

    // Match bits read as all ones while equal
    assign mbits_val = match_flag_q ? MBITS_ALL_ONES : MATCH_ZERO;

    // Byte 0 shows the live count, the rest the frozen snapshot
    assign cnt_view = {hold_q[CNT_W-1:8], cnt_q[7:0]};
    assign cnt_byte = cnt_view[8*cnt_sel[2:0] +: 8];
    assign match_byte = match_val[8*match_sel[2:0] +: 8];
    assign mbits_byte = mbits_val[8*mbits_sel[2:0] +: 8];

    // Control byte with the live match state on top
    assign ctrl_byte = {3'b000, match_flag_q, ctrl_q.mode,
                        ctrl_q.xen, ctrl_q.autoclr};

    // Read data selection, one byte in the low lane
    always_comb begin
        rdata_d = RDATA_NONE;
        if (take_rd) begin
            if (in_cnt) begin
                rdata_d = {24'h00_0000, cnt_byte};
            end else if (in_match) begin
                rdata_d = {24'h00_0000, match_byte};
            end else if (in_mbits) begin
                rdata_d = {24'h00_0000, mbits_byte};
            end else begin
                rdata_d = {24'h00_0000, ctrl_byte};
            end
        end
    end

    // Data phase registers of the bus slave
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            req_q <= '0;
            rdata_q <= RDATA_NONE;
        end else begin
            req_q <= req_d;
            if (take) begin
                rdata_q <= rdata_d;
            end
        end
    end

    // Outputs

    // Zero-wait slave, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign hrdata = rdata_q;

    // Crystal controls follow the control fields
    assign crystal_mode_out = ctrl_q.mode;
    assign crystal_select_out = ctrl_q.xen;

    // Match to fabric and to the power state machine
    assign match_out = match_flag_q;
    assign power_sm_match_out = match_flag_q;

endmodule : rtc_match_counter

// ### rtl/rtc_match_pkg.sv
// Constants, register map and carriers for the real-time match counter
package rtc_match_pkg;

    // Counter geometry
    localparam int unsigned CNT_W = 40;
    localparam int unsigned CNT_BYTES = 5;

    // Prescaler: divide the input clock edges by this figure
    localparam int unsigned PRESCALE_DIV = 128;
    localparam int unsigned PRESCALE_W = $clog2(PRESCALE_DIV);
    localparam logic [PRESCALE_W-1:0] PRESCALE_LAST =
        PRESCALE_W'(PRESCALE_DIV - 1);

    // Word index of each register (byte address is four times the index)
    localparam logic [5:0] IDX_CNT = 6'h00;
    localparam logic [5:0] IDX_MATCH = 6'h05;
    localparam logic [5:0] IDX_MBITS = 6'h0a;
    localparam logic [5:0] IDX_CTRL = 6'h0f;

    // Byte offsets, derived from the indices
    localparam logic [7:0] OFF_CNT = {IDX_CNT, 2'b00};
    localparam logic [7:0] OFF_MATCH = {IDX_MATCH, 2'b00};
    localparam logic [7:0] OFF_MBITS = {IDX_MBITS, 2'b00};
    localparam logic [7:0] OFF_CTRL = {IDX_CTRL, 2'b00};

    // Control/status byte field positions
    localparam int unsigned CTRL_AUTOCLR_BIT = 0;
    localparam int unsigned CTRL_XEN_BIT = 1;
    localparam int unsigned CTRL_MODE_LSB = 2;
    localparam int unsigned CTRL_MATCH_BIT = 4;

    // Reset values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [CNT_W-1:0] CNT_RESET = 40'h00_0000_0000;
    localparam logic [CNT_W-1:0] MATCH_RESET = 40'h00_0000_0000;
    localparam logic [CNT_W-1:0] CNT_CLEAR = 40'h00_0000_0000;
    localparam logic [CNT_W-1:0] MATCH_ZERO = 40'h00_0000_0000;
    localparam logic [CNT_W-1:0] MBITS_ALL_ONES = 40'hff_ffff_ffff;

    // Bus answer constants
    localparam logic [31:0] RDATA_NONE = 32'h0000_0000;
    localparam logic HRESP_OKAY = 1'b0;

    // Control fields held by software
    typedef struct packed {
        logic [1:0] mode;
        logic xen;
        logic autoclr;
    } ctrl_s;

    // Latched address phase of a bus transfer
    typedef struct packed {
        logic [5:0] idx;
        logic write;
        logic valid;
    } bus_req_s;

endpackage : rtc_match_pkg

// ### rtl/rtc_prescaler.sv
// Divide-by-128 prescaler on the edges of the counter input clock
`timescale 1ns/100ps
module rtc_prescaler
    import rtc_match_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic clk_level,
    output logic tick
);

    logic level_q;
    logic [PRESCALE_W-1:0] div_q;
    logic [PRESCALE_W-1:0] div_d;
    logic rise;
    logic wrap;

    // Rising edge of the slow clock, sampled on hclk
    assign rise = clk_level & ~level_q;
    assign wrap = rise && (div_q == PRESCALE_LAST);
    assign div_d = rise ? PRESCALE_W'(div_q + 1'b1) : div_q;

    // Edge history and divide count
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            level_q <= 1'b0;
            div_q <= '0;
            tick <= 1'b0;
        end else begin
            level_q <= clk_level;
            div_q <= div_d;
            tick <= wrap;
        end
    end

endmodule : rtc_prescaler

// ### bench/rtc_xtal_model.sv
// Crystal oscillator clock model feeding the counter input
`timescale 1ns/100ps
module rtc_xtal_model (
    input wire logic hclk,
    input wire logic run,
    output logic rtc_clock_in
);
    initial rtc_clock_in = 1'b0;
    // Toggle each edge while running, stand low between bursts
    always @(posedge hclk) begin
        rtc_clock_in <= run ? !rtc_clock_in : 1'b0;
    end
endmodule : rtc_xtal_model

// ### bench/rtc_match_counter_chk.sv
// Port assertions for the real-time match counter
`timescale 1ns/100ps
module rtc_match_counter_chk
    import rtc_match_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic [31:0] hrdata,
    input wire logic rtc_clock_in,
    input wire logic [1:0] crystal_mode_out,
    input wire logic crystal_select_out,
    input wire logic match_out,
    input wire logic power_sm_match_out
);
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    logic [3:0] quiet_q;
    logic [3:0] quiet_d;
    // Accepted address phases by kind
    wire acc = hsel && htrans[1] && hready;
    wire rd = acc && !hwrite;
    wire wr_ctl = acc && hwrite && hsize == 3'b010
        && haddr == {24'h0, OFF_CTRL};
    wire rd_ctl = rd && haddr == {24'h0, OFF_CTRL};
    wire rd_mb = rd && haddr[31:8] == 24'h0 && haddr[1:0] == 2'b00
        && haddr[7:2] >= IDX_MBITS && haddr[7:2] < IDX_CTRL;
    // Cycles since the last write or high input clock level
    assign quiet_d = (acc && hwrite) || rtc_clock_in ? 4'h0
        : quiet_q + {3'h0, quiet_q != 4'hf};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            quiet_q <= 4'h0;
        end else begin
            quiet_q <= quiet_d;
        end
    end
    psm_mirror_a: assert property (power_sm_match_out == match_out)
        else $error("power match output differs");
    mode_follow_a: assert property (wr_ctl |=> ##1
        crystal_mode_out == $past(hwdata[3:2])) else $error("mode stale");
    select_follow_a: assert property (wr_ctl |=> ##1
        crystal_select_out == $past(hwdata[1])) else $error("select stale");
    mbits_read_a: assert property (rd_mb |=>
        hrdata == ($past(match_out) ? 32'hff : 32'h0))
        else $error("match bits wrong");
    ctrl_match_a: assert property (rd_ctl |=>
        hrdata[31:4] == {27'h0, $past(match_out)})
        else $error("control match bit wrong");
    byte_read_a: assert property (rd |=> hrdata[31:8] == 24'h0)
        else $error("read wider than a byte");
    unmapped_zero_a: assert property (rd && haddr[31:8] != 24'h0
        |=> hrdata == RDATA_NONE) else $error("unmapped read not zero");
    match_quiet_a: assert property (quiet_q > 4'd5 |->
        $stable(match_out)) else $error("match moved without a tick");
endmodule : rtc_match_counter_chk

bind rtc_match_counter rtc_match_counter_chk u_rtc_match_counter_chk (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
    .hrdata(hrdata), .rtc_clock_in(rtc_clock_in),
    .crystal_mode_out(crystal_mode_out),
    .crystal_select_out(crystal_select_out), .match_out(match_out),
    .power_sm_match_out(power_sm_match_out));

// ### bench/rtc_match_counter_tb.sv
// Self-checking bench for the real-time match counter
`timescale 1ns/100ps
module rtc_match_counter_tb;
    import rtc_match_pkg::*;
    logic hclk, hresetn, hsel, hwrite, run, hreadyout, hresp;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans, crystal_mode_out;
    logic [2:0] hsize;
    logic crystal_select_out, match_out, power_sm_match_out, rtc_clock_in;
    wire hready = hreadyout;
    int err_count, checked;
    integer seed = 32'h4e3af366;
    logic [39:0] v, m;
    logic [7:0] b, w;
    rtc_match_counter u_rtc_match_counter (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .rtc_clock_in(rtc_clock_in),
        .crystal_mode_out(crystal_mode_out),
        .crystal_select_out(crystal_select_out), .match_out(match_out),
        .power_sm_match_out(power_sm_match_out));
    rtc_xtal_model u_rtc_xtal_model (
        .hclk(hclk), .run(run), .rtc_clock_in(rtc_clock_in));
    initial begin
        hclk = 1'b0;
        forever #20 hclk = ~hclk;
    end
    // Expected count after one prescaled tick
    function logic [39:0] nxt(input logic [39:0] c, input logic [39:0] mt,
                              input logic ac);
        return (ac && c == mt && mt != 40'h0) ? 40'h0 : c + 40'h1;
    endfunction : nxt
    task chk(input logic [39:0] g, input logic [39:0] e);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // One single-word transfer; read byte lands in b
    task xfer(input logic wr, input logic [31:0] a, input logic [7:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize <= 3'b010;
        do @(posedge hclk); while (!hready);
        htrans <= 2'b00;
        hsel <= 1'b0;
        hwdata <= {24'h0, d};
        do @(posedge hclk); while (!hready);
        b = hrdata[7:0];
    endtask : xfer
    task wr40(input logic [7:0] base, input logic [39:0] d);
        for (int i = 0; i < 5; i++) begin
            xfer(1'b1, {24'h0, base + 8'(4 * i)}, d[8 * i +: 8]);
        end
    endtask : wr40
    task rd40(input logic [7:0] base, output logic [39:0] d);
        for (int i = 0; i < 5; i++) begin
            xfer(1'b0, {24'h0, base + 8'(4 * i)}, 8'h00);
            d[8 * i +: 8] = b;
        end
    endtask : rd40
    // Exactly 128 input clock rises, then let the tick land
    task tick;
        run <= 1'b1;
        repeat (256) @(posedge hclk);
        run <= 1'b0;
        repeat (4) @(posedge hclk);
    endtask : tick
    task test_done;
        $display("checked=%0d err_count=%0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        test_done();
    end
    initial begin
        {hresetn, hsel, haddr, htrans, hwrite, hsize, hwdata, run} = '0;
        repeat (2) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        chk(match_out, 1'b1);
        chk({crystal_mode_out, crystal_select_out}, 3'h0);
        // Every crystal mode with random enable, auto-clear off
        for (int i = 0; i < 4; i++) begin
            w = 8'($random(seed));
            w[3:2] = 2'(i);
            w[0] = 1'b0;
            xfer(1'b1, {24'h0, OFF_CTRL}, w);
            @(posedge hclk);
            chk(crystal_mode_out, w[3:2]);
            chk(crystal_select_out, w[1]);
            xfer(1'b0, {24'h0, OFF_CTRL}, 8'h00);
            // Count and match both zero here, so the match bit reads one
            chk(b, {3'h0, 1'b1, w[3:0]});
        end
        xfer(1'b0, 32'h100, 8'h00);
        chk(b, 8'h00);
        chk(hresp, HRESP_OKAY);
        xfer(1'b1, {24'h0, OFF_MBITS}, 8'h00);
        rd40(OFF_MBITS, v);
        chk(v, MBITS_ALL_ONES);
        // Load, read back, wrap from all ones
        wr40(OFF_MATCH, 40'h5);
        wr40(OFF_CNT, 40'hff_ffff_ffff);
        rd40(OFF_CNT, v);
        chk(v, 40'hff_ffff_ffff);
        tick();
        rd40(OFF_CNT, v);
        chk(v, nxt(40'hff_ffff_ffff, 40'h5, 1'b0));
        // Snapshot taken on byte zero survives a carry
        wr40(OFF_CNT, 40'hff);
        xfer(1'b0, {24'h0, OFF_CNT}, 8'h00);
        tick();
        xfer(1'b0, {24'h0, OFF_CNT + 8'h4}, 8'h00);
        chk(b, 8'h00);
        // Reach a random match value, then auto-clear
        m = 40'({$random(seed), $random(seed)});
        m[4] = 1'b1;
        wr40(OFF_MATCH, m);
        wr40(OFF_CNT, m - 40'h1);
        @(posedge hclk);
        chk(match_out, 1'b0);
        tick();
        chk(match_out, 1'b1);
        chk(power_sm_match_out, 1'b1);
        rd40(OFF_MBITS, v);
        chk(v, MBITS_ALL_ONES);
        xfer(1'b1, {24'h0, OFF_CTRL}, 8'h01);
        tick();
        rd40(OFF_CNT, v);
        chk(v, nxt(m, m, 1'b1));
        rd40(OFF_MBITS, v);
        chk(v, 40'h0);
        // Zero match value keeps counting despite auto-clear
        wr40(OFF_MATCH, MATCH_ZERO);
        wr40(OFF_CNT, 40'h0);
        tick();
        rd40(OFF_CNT, v);
        chk(v, nxt(40'h0, 40'h0, 1'b1));
        test_done();
    end
endmodule : rtc_match_counter_tb
